// ---- core/sbs_map.svh ----
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SBS_OFF_TX_CTRL 4'h0
`define SBS_OFF_RX_CTRL 4'h1
`define SBS_OFF_BAUD_CTRL 4'h2
`define SBS_OFF_THR 4'h3
`define SBS_OFF_RDR 4'h4
`define SBS_OFF_FLAGS 4'h5
`define SBS_OFF_DIV_LO 4'h6
`define SBS_OFF_DIV_HI 4'h7
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SBS_TX_MASTER 7
`define SBS_TX_ENABLE 5
`define SBS_TX_SYNC 4
`define SBS_TX_BREAK 3
`define SBS_TX_EMPTY 1
`define SBS_RX_PORT 7
`define SBS_RX_SINGLE 5
`define SBS_RX_CONT 4
`define SBS_RX_FRAME_ERR 2
`define SBS_BC_DPI 5
`define SBS_BC_CPI 4
`define SBS_BC_WAKE 1
`define SBS_BC_ABD 0
`define SBS_FL_TBE 0
`define SBS_FL_RCV 1
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define SBS_DIV_RST 16'h0004
`define SBS_DATA_LAST 4'h7
`define SBS_BREAK_LAST 4'hB
`endif

// ---- core/sbs_pkg.sv ----
`default_nettype none
package sbs_pkg;
  typedef enum logic [2:0] {
    SBS_TX_IDLE = 3'b000,
    SBS_TX_START = 3'b001,
    SBS_TX_DATA = 3'b010,
    SBS_TX_STOP = 3'b011,
    SBS_TX_SYNC = 3'b100
  } sbs_tx_state_t;

  typedef enum logic [1:0] {
    SBS_RX_IDLE = 2'b00,
    SBS_RX_START = 2'b01,
    SBS_RX_DATA = 2'b10,
    SBS_RX_STOP = 2'b11
  } sbs_rx_state_t;

  typedef struct packed {
    logic tx_en;
    logic sync_sel;
    logic master;
    logic brk_req;
    logic port_en;
    logic single_rx;
    logic cont_rx;
    logic dpi;
    logic cpi;
    logic wake_en;
    logic baud_det;
    logic [15:0] div;
    logic [7:0] thr;
    logic thr_full;
    logic [7:0] tx_shift;
    sbs_tx_state_t tx_st;
    logic tx_brk;
    logic [3:0] tx_cnt;
    logic tx_ph;
    logic [15:0] tx_div;
    logic tx_line;
    logic ck_line;
    logic dt_line;
    logic rs1;
    logic rs2;
    logic rs3;
    logic rx_lvl;
    logic rx_prev;
    logic wake_fell;
    sbs_rx_state_t rx_st;
    logic [3:0] rx_cnt;
    logic rx_ph;
    logic [15:0] rx_div;
    logic [7:0] rx_sh;
    logic [7:0] rcv;
    logic rcv_flag;
    logic frame_err;
    logic [7:0] rdata;
  } sbs_state_t;
endpackage
`default_nettype wire

// ---- core/sbs_top.sv ----
// Behaviour
// - Break is start bit, twelve zero bits, then stop bit.
// - Holding write with break request and transmit enable sends a Break of zeros.
// - Hardware clears break request after Break stop bit; next byte may wait.
// - Shift empty flag shows busy or idle during Break as for normal characters.
// - Buffer empty flag rises when holding register empties; then write next byte.
// - Received Break shows receive flag, framing error and data zero.
// - Wake-on-break watches two transitions, flags receive, then receives next byte.
// - Receiver stays idle while wake-on-break enable is set.
// - Synchronous characters carry no start or stop bits.
// - Synchronous mode uses one shared data line and a clock line, half-duplex.
// - Sync master transmit needs sync, master, port enable, both receive enables clear.
// - Master drives shift clock on clock pin, output enabled in sync modes.
// - Exactly one clock cycle per data bit, none beyond the character.
// - Data changes on leading clock edge and holds until the next leading edge.
// - Clock invert idles high; clear idles low; edges follow idle level.
// - Sync master transmit sends on data pin with both pin drivers enabled.
// - Byte written while shifting waits in holding register until last bit sent.
// - With shift register empty, written byte moves at once and shifting starts.
// - Shift register is neither readable nor writable by software.
// - Data invert resets to zero; set inverts transmitted and received data.
// - Under wake-on-break a falling edge wakes; later rising edge clears the enable.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_map.svh"
module sbs_top
  import sbs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_data_pin_i,
  output logic rx_data_pin_o,
  output logic rx_data_pin_oe_o,
  output logic tx_clock_pin_o,
  output logic tx_clock_pin_oe_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // One half bit lasts div+1 clocks; both directions share this
  function automatic logic half_done(input logic [15:0] cnt, input logic [15:0] dv);
    half_done = (cnt == dv);
  endfunction

  function automatic logic [15:0] half_next(input logic [15:0] cnt, input logic [15:0] dv);
    half_next = (cnt == dv) ? 16'h0000 : cnt + 16'h0001;
  endfunction

  sbs_state_t cur;
  sbs_state_t nxt;

  logic async_tx_ok;
  logic sync_tx_mode;
  logic async_rx_ok;
  logic rxb;
  logic fell;
  logic rose;
  logic tx_half;
  logic tx_bit_end;
  logic rx_half;
  logic wr_thr;

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  // Any receive enable steers a sync master away from transmit
  assign sync_tx_mode = cur.sync_sel & cur.master & cur.port_en & ~cur.single_rx & ~cur.cont_rx;
  assign async_tx_ok = ~cur.sync_sel & cur.port_en;
  assign async_rx_ok = ~cur.sync_sel & cur.port_en & cur.cont_rx;
  assign rxb = cur.rx_lvl ^ cur.dpi;
  assign fell = cur.rx_prev & ~rxb;
  assign rose = ~cur.rx_prev & rxb;
  assign tx_half = half_done(cur.tx_div, cur.div);
  assign tx_bit_end = tx_half & cur.tx_ph;
  assign rx_half = half_done(cur.rx_div, cur.div);
  assign wr_thr = wr_i & (addr_i == `SBS_OFF_THR);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    nxt = cur;
    // Pin synchroniser; only the last two stages are compared
    nxt.rs1 = rx_data_pin_i;
    nxt.rs2 = cur.rs1;
    nxt.rs3 = cur.rs2;
    if (cur.rs2 == cur.rs3)
    begin
      nxt.rx_lvl = cur.rs3;
    end
    nxt.rx_prev = rxb;

    // Transmit half-bit timer
    nxt.tx_div = half_next(cur.tx_div, cur.div);
    if (tx_half)
    begin
      nxt.tx_ph = ~cur.tx_ph;
    end

    // Transmitter; a dropped enable aborts the character
    case (cur.tx_st)
      SBS_TX_IDLE:
      begin
        nxt.tx_div = 16'h0000;
        nxt.tx_ph = 1'b0;
        nxt.tx_cnt = 4'h0;
        if (cur.thr_full && cur.tx_en && (async_tx_ok || sync_tx_mode))
        begin
          nxt.tx_shift = cur.thr;
          nxt.thr_full = 1'b0;
          // Break is decided at transfer, so a sync byte written meanwhile stays data
          nxt.tx_brk = cur.brk_req & ~cur.sync_sel;
          nxt.tx_st = sync_tx_mode ? SBS_TX_SYNC : SBS_TX_START;
        end
      end
      SBS_TX_START:
      begin
        if (tx_bit_end)
        begin
          nxt.tx_st = SBS_TX_DATA;
        end
      end
      SBS_TX_DATA:
      begin
        if (tx_bit_end)
        begin
          nxt.tx_shift = {1'b0, cur.tx_shift[7:1]};
          nxt.tx_cnt = cur.tx_cnt + 4'h1;
          if (cur.tx_cnt == (cur.tx_brk ? `SBS_BREAK_LAST : `SBS_DATA_LAST))
          begin
            nxt.tx_st = SBS_TX_STOP;
          end
        end
      end
      SBS_TX_STOP:
      begin
        if (tx_bit_end)
        begin
          nxt.tx_st = SBS_TX_IDLE;
          if (cur.tx_brk)
          begin
            nxt.brk_req = 1'b0;
          end
        end
      end
      SBS_TX_SYNC:
      begin
        // Eight bits then stop, no trailing clock cycles
        if (tx_bit_end)
        begin
          nxt.tx_shift = {1'b0, cur.tx_shift[7:1]};
          nxt.tx_cnt = cur.tx_cnt + 4'h1;
          if (cur.tx_cnt == `SBS_DATA_LAST)
          begin
            nxt.tx_st = SBS_TX_IDLE;
          end
        end
      end
      default:
      begin
        nxt.tx_st = SBS_TX_IDLE;
      end
    endcase
    if (!cur.tx_en || !(async_tx_ok || sync_tx_mode))
    begin
      nxt.tx_st = SBS_TX_IDLE;
    end

    // Receive half-bit timer
    nxt.rx_div = half_next(cur.rx_div, cur.div);
    if (rx_half)
    begin
      nxt.rx_ph = ~cur.rx_ph;
    end

    // Asynchronous receiver; wake-on-break holds it idle
    case (cur.rx_st)
      SBS_RX_IDLE:
      begin
        nxt.rx_div = 16'h0000;
        nxt.rx_ph = 1'b0;
        nxt.rx_cnt = 4'h0;
        if (cur.wake_en)
        begin
          if (fell)
          begin
            nxt.wake_fell = 1'b1;
            nxt.rcv_flag = 1'b1;
          end
          else if (rose && cur.wake_fell)
          begin
            nxt.wake_en = 1'b0;
            nxt.wake_fell = 1'b0;
          end
        end
        else if (async_rx_ok && fell)
        begin
          nxt.rx_st = SBS_RX_START;
        end
      end
      SBS_RX_START:
      begin
        // Check mid start bit; a glitch returns to idle
        if (rx_half)
        begin
          nxt.rx_st = rxb ? SBS_RX_IDLE : SBS_RX_DATA;
          nxt.rx_div = 16'h0000;
          nxt.rx_ph = 1'b0;
        end
      end
      SBS_RX_DATA:
      begin
        if (rx_half && cur.rx_ph)
        begin
          nxt.rx_sh = {rxb, cur.rx_sh[7:1]};
          nxt.rx_cnt = cur.rx_cnt + 4'h1;
          if (cur.rx_cnt == `SBS_DATA_LAST)
          begin
            nxt.rx_st = SBS_RX_STOP;
          end
        end
      end
      SBS_RX_STOP:
      begin
        // A Break lands here as zero data with a low stop bit
        if (rx_half && cur.rx_ph)
        begin
          nxt.rcv = cur.rx_sh;
          nxt.frame_err = ~rxb;
          nxt.rcv_flag = 1'b1;
          nxt.rx_st = SBS_RX_IDLE;
        end
      end
      default:
      begin
        nxt.rx_st = SBS_RX_IDLE;
      end
    endcase
    if (!async_rx_ok && !cur.wake_en)
    begin
      nxt.rx_st = SBS_RX_IDLE;
    end

    // Register reads; data stands one cycle after the strobe
    nxt.rdata = 8'h00;
    if (rd_i)
    begin
      if (addr_i == `SBS_OFF_TX_CTRL)
      begin
        nxt.rdata[`SBS_TX_MASTER] = cur.master;
        nxt.rdata[`SBS_TX_ENABLE] = cur.tx_en;
        nxt.rdata[`SBS_TX_SYNC] = cur.sync_sel;
        nxt.rdata[`SBS_TX_BREAK] = cur.brk_req;
        nxt.rdata[`SBS_TX_EMPTY] = (cur.tx_st == SBS_TX_IDLE);
      end
      else if (addr_i == `SBS_OFF_RX_CTRL)
      begin
        nxt.rdata[`SBS_RX_PORT] = cur.port_en;
        nxt.rdata[`SBS_RX_SINGLE] = cur.single_rx;
        nxt.rdata[`SBS_RX_CONT] = cur.cont_rx;
        nxt.rdata[`SBS_RX_FRAME_ERR] = cur.frame_err;
      end
      else if (addr_i == `SBS_OFF_BAUD_CTRL)
      begin
        nxt.rdata[`SBS_BC_DPI] = cur.dpi;
        nxt.rdata[`SBS_BC_CPI] = cur.cpi;
        nxt.rdata[`SBS_BC_WAKE] = cur.wake_en;
        nxt.rdata[`SBS_BC_ABD] = cur.baud_det;
      end
      else if (addr_i == `SBS_OFF_RDR)
      begin
        nxt.rdata = cur.rcv;
        // Clear loses to a receive event in the same cycle
        nxt.rcv_flag = nxt.rcv_flag & ~cur.rcv_flag;
        if (cur.rx_st == SBS_RX_STOP && rx_half && cur.rx_ph)
        begin
          nxt.rcv_flag = 1'b1;
        end
        if (cur.wake_en && fell && cur.rx_st == SBS_RX_IDLE)
        begin
          nxt.rcv_flag = 1'b1;
        end
      end
      else if (addr_i == `SBS_OFF_FLAGS)
      begin
        nxt.rdata[`SBS_FL_TBE] = ~cur.thr_full;
        nxt.rdata[`SBS_FL_RCV] = cur.rcv_flag;
      end
      else if (addr_i == `SBS_OFF_DIV_LO)
      begin
        nxt.rdata = cur.div[7:0];
      end
      else if (addr_i == `SBS_OFF_DIV_HI)
      begin
        nxt.rdata = cur.div[15:8];
      end
      else
      begin
        // Holding register and unmapped offsets read as zero
        nxt.rdata = 8'h00;
      end
    end

    // Register writes; software write wins over a hardware clear
    if (wr_i)
    begin
      if (addr_i == `SBS_OFF_TX_CTRL)
      begin
        nxt.master = wdata_i[`SBS_TX_MASTER];
        nxt.tx_en = wdata_i[`SBS_TX_ENABLE];
        nxt.sync_sel = wdata_i[`SBS_TX_SYNC];
        nxt.brk_req = wdata_i[`SBS_TX_BREAK];
      end
      else if (addr_i == `SBS_OFF_RX_CTRL)
      begin
        nxt.port_en = wdata_i[`SBS_RX_PORT];
        nxt.single_rx = wdata_i[`SBS_RX_SINGLE];
        nxt.cont_rx = wdata_i[`SBS_RX_CONT];
      end
      else if (addr_i == `SBS_OFF_BAUD_CTRL)
      begin
        nxt.dpi = wdata_i[`SBS_BC_DPI];
        nxt.cpi = wdata_i[`SBS_BC_CPI];
        nxt.wake_en = wdata_i[`SBS_BC_WAKE];
        nxt.baud_det = wdata_i[`SBS_BC_ABD];
        nxt.wake_fell = 1'b0;
      end
      else if (addr_i == `SBS_OFF_DIV_LO)
      begin
        nxt.div[7:0] = wdata_i;
      end
      else if (addr_i == `SBS_OFF_DIV_HI)
      begin
        nxt.div[15:8] = wdata_i;
      end
    end
    // A byte written while shifting waits here for the idle transfer
    if (wr_thr)
    begin
      nxt.thr = wdata_i;
      nxt.thr_full = 1'b1;
    end

    // Pin drive registers follow the next state; sync data holds between characters
    nxt.ck_line = (nxt.tx_st == SBS_TX_SYNC && !nxt.tx_ph) ? ~nxt.cpi : nxt.cpi;
    nxt.dt_line = (nxt.tx_st == SBS_TX_SYNC) ? nxt.tx_shift[0] ^ nxt.dpi : cur.dt_line;
    case (nxt.tx_st)
      SBS_TX_START: nxt.tx_line = 1'b0 ^ nxt.dpi;
      SBS_TX_DATA: nxt.tx_line = (nxt.tx_brk ? 1'b0 : nxt.tx_shift[0]) ^ nxt.dpi;
      default: nxt.tx_line = 1'b1 ^ nxt.dpi;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cur <= '0;
      cur.div <= `SBS_DIV_RST;
      cur.tx_line <= 1'b1;
      cur.rs1 <= 1'b1;
      cur.rs2 <= 1'b1;
      cur.rs3 <= 1'b1;
      cur.rx_lvl <= 1'b1;
      cur.rx_prev <= 1'b1;
      cur.tx_st <= SBS_TX_IDLE;
      cur.rx_st <= SBS_RX_IDLE;
    end
    else
    begin
      cur <= nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Clock pin carries the async line outside synchronous mode
  assign tx_clock_pin_o = cur.sync_sel ? cur.ck_line : cur.tx_line;
  assign tx_clock_pin_oe_o = cur.port_en & (cur.sync_sel ? cur.master : cur.tx_en);
  // Data pin driven only in sync master transmit mode, also between characters
  assign rx_data_pin_o = cur.dt_line;
  assign rx_data_pin_oe_o = sync_tx_mode;
  assign rdata_o = cur.rdata;

endmodule
`default_nettype wire

// ---- dv/sbs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module sbs_chk (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic rx_data_pin_i,
  input wire logic rx_data_pin_o,
  input wire logic rx_data_pin_oe_o,
  input wire logic tx_clock_pin_o,
  input wire logic tx_clock_pin_oe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // ------
  // Register port
  // ------
  sequence s_bc_wr;
    wr_i && addr_i == 4'h2;
  endsequence
  sequence s_bc_rd;
    rd_i && addr_i == 4'h2;
  endsequence
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_thr_reads_zero: assert property (rd_i && addr_i == 4'h3 |=> rdata_o == 8'h00)
    else $error("holding register readable");
  a_unmapped_zero: assert property (rd_i && addr_i > 4'h7 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_bc_readback: assert property (s_bc_wr ##2 s_bc_rd |=> rdata_o[5:4] == $past(wdata_i[5:4], 3))
    else $error("polarity bits not kept");
  // ------
  // Pin drivers and shift clock
  // ------
  a_oe_pair: assert property (rx_data_pin_oe_o |-> tx_clock_pin_oe_o)
    else $error("data driven without clock driver");
  a_rcv_blocks_tx: assert property (wr_i && addr_i == 4'h1 && wdata_i[5:4] != 2'b00 |=> !rx_data_pin_oe_o)
    else $error("data driver on with a receive enable");
  a_port_off_clk: assert property (wr_i && addr_i == 4'h1 && !wdata_i[7] |=> !tx_clock_pin_oe_o)
    else $error("clock driver on with port off");
  a_clk_half: assert property ($changed(tx_clock_pin_o) && rx_data_pin_oe_o |=> $stable(tx_clock_pin_o)[*3])
    else $error("shift clock phase too short");
  a_data_on_edge: assert property ($changed(rx_data_pin_o) && rx_data_pin_oe_o
    && $past(rx_data_pin_oe_o, 2) |-> $changed(tx_clock_pin_o))
    else $error("data moved away from a clock edge");
endmodule
`default_nettype wire

// ---- dv/sbs_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
module sbs_peer (
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic cpi_i,
  output logic line_o
);
  logic [7:0] sh;
  int n;
  // Bus idles recessive high through its pull-up
  initial line_o = 1'b1;
  // Async sender, bit time 80 ns, phase unrelated to the system clock
  task automatic send(input int nbits, input logic [15:0] v);
    #3;
    for (int i = 0; i < nbits; i++)
    begin
      line_o = v[i];
      #80;
    end
    line_o = 1'b1;
    #80;
  endtask
  // Slave samples on the trailing edge, which returns the clock to idle
  always @(sclk_i)
  begin
    if (sclk_i === cpi_i)
    begin
      sh = {sdata_i, sh[7:1]};
      n++;
    end
  end
endmodule
`default_nettype wire

// ---- dv/sbs_top_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module sbs_top_test;
  logic mclk_i, reset_i, wr_i, rd_i, cpi, rx_o, rx_oe, ck_o, ck_oe, line;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [15:0] v;
  int errors, n_compared;
  // Shared data wire: the port wins while it drives, else the far node
  wire logic rx_in = rx_oe ? rx_o : line;
  sbs_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_data_pin_i(rx_in), .rx_data_pin_o(rx_o),
    .rx_data_pin_oe_o(rx_oe), .tx_clock_pin_o(ck_o), .tx_clock_pin_oe_o(ck_oe));
  sbs_peer peer_u (.sclk_i(ck_o), .sdata_i(rx_o), .cpi_i(cpi), .line_o(line));
  // ------
  // Helpers
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk({8'h00, rdata_o & m}, {8'h00, e});
    @(posedge mclk_i);
  endtask
  // Samples n async bits mid-cell, starting at the start bit
  task automatic cap(input int n);
    int k = 0;
    v = '0;
    while (ck_o && k < 3000)
    begin
      @(posedge mclk_i);
      k++;
    end
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < n; i++)
    begin
      v[i] = ck_o;
      repeat (i < n - 1 ? 8 : 0) @(posedge mclk_i);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    rd(4'h0, 8'hFF, 8'h02);
    rd(4'h2, 8'hFF, 8'h00);
    rd(4'h3, 8'hFF, 8'h00);
    rd(4'hF, 8'hFF, 8'h00);
    rd(4'h5, 8'h01, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h30);
    rd(4'h2, 8'h30, 8'h30);
    wr(4'h2, 8'h00);
    $display("registers done");
  endtask
  // Break with the sync byte queued behind it
  task automatic t_brk_tx;
    wr(4'h6, 8'h03);
    wr(4'h1, 8'h80);
    wr(4'h0, 8'h28);
    wr(4'h3, 8'hFF);
    fork
      cap(14);
      begin
        wr(4'h3, 8'h55);
        rd(4'h0, 8'h02, 8'h00);
        rd(4'h5, 8'h01, 8'h00);
      end
    join
    chk(v, 16'h2000);
    cap(10);
    chk(v, 16'h02AA);
    repeat (10) @(posedge mclk_i);
    rd(4'h0, 8'h0A, 8'h02);
    rd(4'h5, 8'h01, 8'h01);
    $display("break send done");
  endtask
  task automatic t_brk_rx;
    wr(4'h1, 8'h90);
    peer_u.send(14, 16'h2000);
    repeat (20) @(posedge mclk_i);
    rd(4'h5, 8'h02, 8'h02);
    rd(4'h1, 8'h04, 8'h04);
    rd(4'h4, 8'hFF, 8'h00);
    $display("break receive done");
  endtask
  task automatic t_wake;
    wr(4'h2, 8'h03);
    peer_u.send(14, 16'h2000);
    repeat (20) @(posedge mclk_i);
    rd(4'h5, 8'h02, 8'h02);
    rd(4'h2, 8'h02, 8'h00);
    rd(4'h2, 8'h01, 8'h01);
    rd(4'h4, 8'hFF, 8'h00);
    rd(4'h5, 8'h02, 8'h00);
    peer_u.send(10, 16'h0278);
    repeat (20) @(posedge mclk_i);
    rd(4'h5, 8'h02, 8'h02);
    rd(4'h4, 8'hFF, 8'h3C);
    $display("wake done");
  endtask
  // Both clock polarities, then inverted data; two bytes back to back
  task automatic t_sync;
    for (int c = 0; c < 3; c++)
    begin
      cpi <= (c == 1);
      wr(4'h1, 8'h80);
      wr(4'h2, {2'b00, c == 2, c == 1, 4'h0});
      wr(4'h0, 8'hB0);
      repeat (10) @(posedge mclk_i);
      peer_u.n = 0;
      chk({ck_o, rx_oe, ck_oe}, {cpi, 2'b11});
      wr(4'h3, 8'h1E);
      wr(4'h3, 8'hB4);
      repeat (200) @(posedge mclk_i);
      chk(16'(peer_u.n), 16'd16);
      chk({8'h00, peer_u.sh}, c == 2 ? 16'h004B : 16'h00B4);
      wr(4'h0, 8'h00);
    end
    wr(4'h0, 8'hB0);
    wr(4'h1, 8'hA0);
    chk({15'h0, rx_oe}, 16'h0000);
    wr(4'h1, 8'h80);
    chk({15'h0, rx_oe}, 16'h0001);
    wr(4'h0, 8'h00);
    $display("sync master done");
  endtask
  // ------
  // Clock, sequence, watchdog
  // ------
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial
  begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    cpi = 1'b0;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    t_regs();
    t_brk_tx();
    t_brk_rx();
    t_wake();
    t_sync();
    report_and_stop();
  end
  // Whole run needs about 1350 cycles; this is ample margin
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
bind sbs_top sbs_chk chk_u (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_data_pin_i(rx_data_pin_i), .rx_data_pin_o(rx_data_pin_o),
  .rx_data_pin_oe_o(rx_data_pin_oe_o), .tx_clock_pin_o(tx_clock_pin_o), .tx_clock_pin_oe_o(tx_clock_pin_oe_o));
`default_nettype wire
